// >>> src/hfa_host_fifo_port.v
// Host access logic: four FIFO ports and attribute-typed control/status words
`include "hfa_consts.vh"

// Functional notes
// - Read-only fields ignore host writes
// - Write-only register reads back zero
// - Writing one clears bit, zero keeps
// - Read-to-clear bit cleared by host read
// - Latched low/high bits released on read
// - Immune field survives soft reset
// - Both resets load default values, except the immune field, which soft reset leaves as it is
// - Four queues: rx status/data, tx status/data
// - Rx status, rx data and tx data capacities set by control word; tx status fixed at DEPTH
// - Writes to receive queue ports ignored
// - Rx status pop read removes head
// - Rx status view read keeps head
// - Each rx data read pops head
// - Rx data port aliased over 16 words
// - Tx status pop read removes head
// - Tx status view read keeps head
// - Tx data port write-only
// - Tx data port aliased over 16 words
module hfa_host_fifo_port #(
   parameter DW    = 32,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire                   ref_clk,
   input  wire                   arst_n,
   input  wire                   host_cs,
   input  wire                   host_rd,
   input  wire                   host_wr,
   input  wire [`HFA_ADDR_W-1:0] host_addr,
   input  wire [DW-1:0]          host_wdata,
   output reg  [DW-1:0]          host_rdata_q,
   input  wire                   rxs_in_valid,
   output wire                   rxs_in_ready,
   input  wire [DW-1:0]          rxs_in_data,
   input  wire                   rxd_in_valid,
   output wire                   rxd_in_ready,
   input  wire [DW-1:0]          rxd_in_data,
   input  wire                   txs_in_valid,
   output wire                   txs_in_ready,
   input  wire [DW-1:0]          txs_in_data,
   output wire                   txd_out_valid,
   input  wire                   txd_out_ready,
   output wire [DW-1:0]          txd_out_data,
   input  wire                   link_up,
   input  wire                   err_evt,
   output reg                    soft_rst_q,
   output reg  [`HFA_KEEP_W-1:0] keep_q,
   output reg  [DW-1:0]          wo_q
);
   // Access tracking
   reg                    rd_seen_q;
   reg                    wr_seen_q;
   wire                   rd_first;
   wire                   wr_first;

   // Address decode results
   reg                    sel_rxd;
   reg                    sel_txd;
   reg                    sel_rxs_pop;
   reg                    sel_rxs_view;
   reg                    sel_txs_pop;
   reg                    sel_txs_view;
   reg                    sel_ctrl;
   reg                    sel_sts;
   reg                    sel_wo;

   // Control word
   reg  [`HFA_CAP_W-1:0]  rxd_cap_q;
   reg  [`HFA_CAP_W-1:0]  rxs_cap_q;
   reg  [`HFA_CAP_W-1:0]  txd_cap_q;

   // Status bits
   reg                    ovr_q;
   reg                    txs_evt_q;
   reg                    link_ll_q;
   reg                    err_lh_q;

   // Queue wiring
   wire [DW-1:0]          rxs_head;
   wire [DW-1:0]          rxd_head;
   wire [DW-1:0]          txs_head;
   wire                   rxs_out_valid;
   wire                   rxd_out_valid;
   wire                   txs_out_valid;
   wire                   txd_in_ready;
   wire [AW:0]            rxs_cnt;
   wire [AW:0]            rxd_cnt;
   wire [AW:0]            txs_cnt;
   wire [AW:0]            txd_cnt;
   wire                   rxs_pop;
   wire                   rxd_pop;
   wire                   txs_pop;
   wire                   txd_push;
   wire                   txs_fire;
   wire                   sts_read;
   wire                   ctrl_wr;
   wire [AW:0]            rxd_cap;
   wire [AW:0]            rxs_cap;
   wire [AW:0]            txd_cap;
   wire [AW:0]            txs_cap;
   reg  [DW-1:0]          rdata_d;
   reg  [DW-1:0]          ctrl_view;
   reg  [DW-1:0]          sts_view;

   // A bus cycle split into several strobes under one select
   // still counts as a single access
   assign rd_first = host_cs & host_rd & ~rd_seen_q;
   assign wr_first = host_cs & host_wr & ~wr_seen_q;

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_seen_q <= 1'b0;
         wr_seen_q <= 1'b0;
      end else if (!host_cs) begin
         rd_seen_q <= 1'b0;
         wr_seen_q <= 1'b0;
      end else begin
         rd_seen_q <= rd_seen_q | host_rd;
         wr_seen_q <= wr_seen_q | host_wr;
      end
   end

   always @* begin
      sel_rxd      = 1'b0;
      sel_txd      = 1'b0;
      sel_rxs_pop  = 1'b0;
      sel_rxs_view = 1'b0;
      sel_txs_pop  = 1'b0;
      sel_txs_view = 1'b0;
      sel_ctrl     = 1'b0;
      sel_sts      = 1'b0;
      sel_wo       = 1'b0;
      if (host_addr[`HFA_ADDR_W-1:`HFA_PAGE_LSB] == `HFA_PAGE_RXD) begin
         sel_rxd = 1'b1;
      end else if (host_addr[`HFA_ADDR_W-1:`HFA_PAGE_LSB] == `HFA_PAGE_TXD)
      begin
         sel_txd = 1'b1;
      end else if (host_addr == `HFA_RXS_POP) begin
         sel_rxs_pop = 1'b1;
      end else if (host_addr == `HFA_RXS_VIEW) begin
         sel_rxs_view = 1'b1;
      end else if (host_addr == `HFA_TXS_POP) begin
         sel_txs_pop = 1'b1;
      end else if (host_addr == `HFA_TXS_VIEW) begin
         sel_txs_view = 1'b1;
      end else if (host_addr == `HFA_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (host_addr == `HFA_STS) begin
         sel_sts = 1'b1;
      end else if (host_addr == `HFA_WO) begin
         sel_wo = 1'b1;
      end
   end

   // Pops only on the first read strobe; reading an empty queue
   // returns zero and removes nothing
   assign rxs_pop  = rd_first & sel_rxs_pop & rxs_out_valid;
   assign rxd_pop  = rd_first & sel_rxd & rxd_out_valid;
   assign txs_pop  = rd_first & sel_txs_pop & txs_out_valid;
   // Host writes to a full transmit queue are dropped
   assign txd_push = wr_first & sel_txd;
   assign sts_read = rd_first & sel_sts;
   assign ctrl_wr  = wr_first & sel_ctrl;
   assign txs_fire = txs_in_valid & txs_in_ready;

   assign rxd_cap = {{(AW+1-`HFA_CAP_W){1'b0}}, rxd_cap_q};
   assign rxs_cap = {{(AW+1-`HFA_CAP_W){1'b0}}, rxs_cap_q};
   assign txd_cap = {{(AW+1-`HFA_CAP_W){1'b0}}, txd_cap_q};
   assign txs_cap = DEPTH[AW:0];

   // Four queues reachable by the host
   hfa_fifo #(.W(DW), .D(DEPTH), .AW(AW)) u_rxs (
      .clk         (ref_clk),
      .arst_n      (arst_n),
      .clr         (soft_rst_q),
      .cap         (rxs_cap),
      .in_valid    (rxs_in_valid),
      .in_ready_q  (rxs_in_ready),
      .in_data     (rxs_in_data),
      .out_valid_q (rxs_out_valid),
      .out_ready   (rxs_pop),
      .out_data    (rxs_head),
      .cnt_q       (rxs_cnt)
   );

   hfa_fifo #(.W(DW), .D(DEPTH), .AW(AW)) u_rxd (
      .clk         (ref_clk),
      .arst_n      (arst_n),
      .clr         (soft_rst_q),
      .cap         (rxd_cap),
      .in_valid    (rxd_in_valid),
      .in_ready_q  (rxd_in_ready),
      .in_data     (rxd_in_data),
      .out_valid_q (rxd_out_valid),
      .out_ready   (rxd_pop),
      .out_data    (rxd_head),
      .cnt_q       (rxd_cnt)
   );

   hfa_fifo #(.W(DW), .D(DEPTH), .AW(AW)) u_txs (
      .clk         (ref_clk),
      .arst_n      (arst_n),
      .clr         (soft_rst_q),
      .cap         (txs_cap),
      .in_valid    (txs_in_valid),
      .in_ready_q  (txs_in_ready),
      .in_data     (txs_in_data),
      .out_valid_q (txs_out_valid),
      .out_ready   (txs_pop),
      .out_data    (txs_head),
      .cnt_q       (txs_cnt)
   );

   hfa_fifo #(.W(DW), .D(DEPTH), .AW(AW)) u_txd (
      .clk         (ref_clk),
      .arst_n      (arst_n),
      .clr         (soft_rst_q),
      .cap         (txd_cap),
      .in_valid    (txd_push),
      .in_ready_q  (txd_in_ready),
      .in_data     (host_wdata),
      .out_valid_q (txd_out_valid),
      .out_ready   (txd_out_ready),
      .out_data    (txd_out_data),
      .cnt_q       (txd_cnt)
   );

   // Control word: capacities, soft reset, reset-immune field
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxd_cap_q  <= `HFA_CAP_RST;
         rxs_cap_q  <= `HFA_CAP_RST;
         txd_cap_q  <= `HFA_CAP_RST;
         soft_rst_q <= 1'b0;
         keep_q     <= `HFA_KEEP_RST;
      end else begin
         // Held for one cycle, then drops by itself
         soft_rst_q <= ctrl_wr & host_wdata[`HFA_SRST_BIT];
         if (ctrl_wr) begin
            keep_q <= host_wdata[`HFA_KEEP_LSB +: `HFA_KEEP_W];
         end
         if (soft_rst_q) begin
            rxd_cap_q <= `HFA_CAP_RST;
            rxs_cap_q <= `HFA_CAP_RST;
            txd_cap_q <= `HFA_CAP_RST;
         end else if (ctrl_wr) begin
            rxd_cap_q <= host_wdata[`HFA_RXD_CAP_LSB +: `HFA_CAP_W];
            rxs_cap_q <= host_wdata[`HFA_RXS_CAP_LSB +: `HFA_CAP_W];
            txd_cap_q <= host_wdata[`HFA_TXD_CAP_LSB +: `HFA_CAP_W];
         end
      end
   end

   // Write-only word; its reads return zero below
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wo_q <= `HFA_WORD_ZERO;
      end else if (soft_rst_q) begin
         wo_q <= `HFA_WORD_ZERO;
      end else if (wr_first & sel_wo) begin
         wo_q <= host_wdata;
      end
   end

   // Status bits; a new event in the clearing cycle wins
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ovr_q     <= 1'b0;
         txs_evt_q <= 1'b0;
         link_ll_q <= 1'b0;
         err_lh_q  <= 1'b0;
      end else if (soft_rst_q) begin
         ovr_q     <= 1'b0;
         txs_evt_q <= 1'b0;
         link_ll_q <= 1'b0;
         err_lh_q  <= 1'b0;
      end else begin
         if (rxd_in_valid & ~rxd_in_ready) begin
            ovr_q <= 1'b1;
         end else if (wr_first & sel_sts & host_wdata[`HFA_OVR_BIT]) begin
            ovr_q <= 1'b0;
         end
         if (txs_fire) begin
            txs_evt_q <= 1'b1;
         end else if (sts_read) begin
            txs_evt_q <= 1'b0;
         end
         // Low is held until read, then the live level is taken
         if (!link_up) begin
            link_ll_q <= 1'b0;
         end else if (sts_read) begin
            link_ll_q <= 1'b1;
         end
         if (err_evt) begin
            err_lh_q <= 1'b1;
         end else if (sts_read) begin
            err_lh_q <= 1'b0;
         end
      end
   end

   always @* begin
      ctrl_view = `HFA_WORD_ZERO;
      ctrl_view[`HFA_RXD_CAP_LSB +: `HFA_CAP_W] = rxd_cap_q;
      ctrl_view[`HFA_RXS_CAP_LSB +: `HFA_CAP_W] = rxs_cap_q;
      ctrl_view[`HFA_TXD_CAP_LSB +: `HFA_CAP_W] = txd_cap_q;
      ctrl_view[`HFA_KEEP_LSB +: `HFA_KEEP_W]   = keep_q;
      ctrl_view[`HFA_SRST_BIT]                  = soft_rst_q;
   end

   // Queue levels are read-only; no write path reaches them
   always @* begin
      sts_view = `HFA_WORD_ZERO;
      sts_view[`HFA_OVR_BIT]              = ovr_q;
      sts_view[`HFA_TXS_EVT_BIT]          = txs_evt_q;
      sts_view[`HFA_LINK_BIT]             = link_ll_q;
      sts_view[`HFA_ERR_BIT]              = err_lh_q;
      sts_view[`HFA_RXD_CNT_LSB +: AW+1]  = rxd_cnt;
      sts_view[`HFA_RXS_CNT_LSB +: AW+1]  = rxs_cnt;
      sts_view[`HFA_TXD_CNT_LSB +: AW+1]  = txd_cnt;
      sts_view[`HFA_TXS_CNT_LSB +: AW+1]  = txs_cnt;
   end

   // Read mux; receive ports have no write path at all
   always @* begin
      rdata_d = `HFA_WORD_ZERO;
      if (sel_rxd) begin
         rdata_d = rxd_out_valid ? rxd_head : `HFA_WORD_ZERO;
      end else if (sel_rxs_pop | sel_rxs_view) begin
         rdata_d = rxs_out_valid ? rxs_head : `HFA_WORD_ZERO;
      end else if (sel_txs_pop | sel_txs_view) begin
         rdata_d = txs_out_valid ? txs_head : `HFA_WORD_ZERO;
      end else if (sel_ctrl) begin
         rdata_d = ctrl_view;
      end else if (sel_sts) begin
         rdata_d = sts_view;
      end else if (sel_txd | sel_wo) begin
         rdata_d = `HFA_WORD_ZERO;
      end
   end

   // Captured on the first read strobe and held until the next
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         host_rdata_q <= `HFA_WORD_ZERO;
      end else if (rd_first) begin
         host_rdata_q <= rdata_d;
      end
   end
endmodule // hfa_host_fifo_port

// >>> src/hfa_consts.vh
// Address map, field positions and reset values of the host FIFO port block
`ifndef HFA_CONSTS_VH
`define HFA_CONSTS_VH

// Word index of the host port (one index per 32-bit word)
`define HFA_ADDR_W        6
`define HFA_PAGE_LSB      4
`define HFA_PAGE_RXD      2'h0
`define HFA_PAGE_TXD      2'h1
`define HFA_RXS_POP       6'h20
`define HFA_RXS_VIEW      6'h21
`define HFA_TXS_POP       6'h22
`define HFA_TXS_VIEW      6'h23
`define HFA_CTRL          6'h24
`define HFA_STS           6'h25
`define HFA_WO            6'h26

// Control word fields
`define HFA_CAP_W         3
`define HFA_RXD_CAP_LSB   0
`define HFA_RXS_CAP_LSB   4
`define HFA_TXD_CAP_LSB   8
`define HFA_KEEP_LSB      16
`define HFA_KEEP_W        8
`define HFA_SRST_BIT      31
`define HFA_CAP_RST       3'h4
`define HFA_KEEP_RST      8'h00

// Status word fields
`define HFA_OVR_BIT       0
`define HFA_TXS_EVT_BIT   1
`define HFA_LINK_BIT      2
`define HFA_ERR_BIT       3
`define HFA_RXD_CNT_LSB   8
`define HFA_RXS_CNT_LSB   12
`define HFA_TXD_CNT_LSB   16
`define HFA_TXS_CNT_LSB   20

`define HFA_WORD_ZERO     32'h0000_0000

`endif

// >>> src/hfa_fifo.v
// Small synchronous FIFO with a run-time capacity limit
module hfa_fifo #(
   parameter W  = 32,
   parameter D  = 4,
   parameter AW = 2
) (
   input  wire          clk,
   input  wire          arst_n,
   input  wire          clr,
   input  wire [AW:0]   cap,
   input  wire          in_valid,
   output reg           in_ready_q,
   input  wire [W-1:0]  in_data,
   output reg           out_valid_q,
   input  wire          out_ready,
   output wire [W-1:0]  out_data,
   output reg  [AW:0]   cnt_q
);
   // D must be a power of two so the pointers wrap by themselves
   reg  [W-1:0]  mem [0:D-1];
   reg  [AW-1:0] wr_q;
   reg  [AW-1:0] rd_q;
   wire          in_fire;
   wire          out_fire;
   wire [AW:0]   cnt_d;
   wire [AW:0]   lim;

   assign in_fire  = in_valid & in_ready_q;
   assign out_fire = out_ready & out_valid_q;
   assign cnt_d    = cnt_q + {{AW{1'b0}}, in_fire} - {{AW{1'b0}}, out_fire};
   // Capacity above the array size is clipped to the array size
   assign lim      = (cap > D[AW:0]) ? D[AW:0] : cap;
   assign out_data = mem[rd_q];

   always @(posedge clk) begin
      if (in_fire) begin
         mem[wr_q] <= in_data;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q        <= {AW{1'b0}};
         rd_q        <= {AW{1'b0}};
         cnt_q       <= {(AW+1){1'b0}};
         in_ready_q  <= 1'b0;
         out_valid_q <= 1'b0;
      end else if (clr) begin
         wr_q        <= {AW{1'b0}};
         rd_q        <= {AW{1'b0}};
         cnt_q       <= {(AW+1){1'b0}};
         in_ready_q  <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         if (in_fire) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (out_fire) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         cnt_q       <= cnt_d;
         in_ready_q  <= (cnt_d < lim);
         out_valid_q <= (cnt_d != {(AW+1){1'b0}});
      end
   end
endmodule // hfa_fifo

// >>> test/hfa_host_fifo_port_properties.sv
// Concurrent checks at the host FIFO port block boundary
`include "hfa_consts.vh"
module hfa_host_fifo_port_properties #(
   parameter DW = 32
) (
   input wire                   ref_clk,
   input wire                   arst_n,
   input wire                   host_cs,
   input wire                   host_rd,
   input wire                   host_wr,
   input wire [`HFA_ADDR_W-1:0] host_addr,
   input wire [DW-1:0]          host_wdata,
   input wire [DW-1:0]          host_rdata_q,
   input wire                   txd_out_valid,
   input wire                   txd_out_ready,
   input wire [DW-1:0]          txd_out_data,
   input wire                   soft_rst_q,
   input wire [`HFA_KEEP_W-1:0] keep_q
);
   timeunit 1ns;
   timeprecision 1ns;
   // Only the first strobe of a select stretch acts
   logic rd_seen_q;
   logic wr_seen_q;
   wire  rd_go = host_cs && host_rd && !rd_seen_q;
   wire  wr_go = host_cs && host_wr && !wr_seen_q;
   wire  txd_pg = host_addr[5:4] == `HFA_PAGE_TXD;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_seen_q <= 1'b0;
         wr_seen_q <= 1'b0;
      end else begin
         rd_seen_q <= host_cs && (rd_seen_q || host_rd);
         wr_seen_q <= host_cs && (wr_seen_q || host_wr);
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_srst_wr;
      wr_go && host_addr == `HFA_CTRL && host_wdata[`HFA_SRST_BIT];
   endsequence
   sequence s_rd_again;
      rd_go ##1 (host_cs && host_rd);
   endsequence
   property p_srst_go; s_srst_wr |=> soft_rst_q; endproperty
   property p_srst_pulse; soft_rst_q |=> !soft_rst_q; endproperty
   property p_keep; soft_rst_q |=> $stable(keep_q); endproperty
   property p_wo_zero;
      rd_go && host_addr == `HFA_WO |=> host_rdata_q == `HFA_WORD_ZERO;
   endproperty
   property p_txd_rd; rd_go && txd_pg |=> host_rdata_q == '0; endproperty
   property p_txd_wr;
      wr_go && txd_pg && !txd_out_valid && !soft_rst_q |=> txd_out_valid;
   endproperty
   property p_rd_once; s_rd_again |=> $stable(host_rdata_q); endproperty
   property p_txd_hold;
      txd_out_valid && !txd_out_ready && !soft_rst_q
         |=> txd_out_valid && $stable(txd_out_data);
   endproperty
   a_srst_go: assert property (p_srst_go)
      else $error("soft reset not raised");
   a_srst_pulse: assert property (p_srst_pulse)
      else $error("soft reset pulse too long");
   a_keep: assert property (p_keep)
      else $error("immune field changed");
   a_wo_zero: assert property (p_wo_zero)
      else $error("write-only word read nonzero");
   a_txd_rd: assert property (p_txd_rd)
      else $error("tx data port read nonzero");
   a_txd_wr: assert property (p_txd_wr)
      else $error("tx data write not queued");
   a_rd_once: assert property (p_rd_once)
      else $error("second strobe changed read data");
   a_txd_hold: assert property (p_txd_hold)
      else $error("tx data head not held");
endmodule // hfa_host_fifo_port_properties

// >>> test/hfa_host_model.sv
// Host processor model driving the SRAM-like port
`include "hfa_consts.vh"
module hfa_host_model (
   input  wire         ref_clk,
   output logic        host_cs,
   output logic        host_rd,
   output logic        host_wr,
   output logic [5:0]  host_addr,
   output logic [31:0] host_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      host_cs = 1'b0;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_addr = 6'h00;
      host_wdata = 32'h0;
   end
   // One access per select stretch, strobe held n edges
   task automatic acc(input logic w, input logic [5:0] a,
                      input logic [31:0] d, input int n);
      if (w && a > `HFA_WO) return;
      @(posedge ref_clk);
      host_cs <= 1'b1;
      host_rd <= !w;
      host_wr <= w;
      host_addr <= a;
      host_wdata <= (a == `HFA_CTRL) ? d & 32'h80ff_0777 : d;
      repeat (n) @(posedge ref_clk);
      host_cs <= 1'b0;
      host_rd <= 1'b0;
      host_wr <= 1'b0;
      // Released bus shows garbage, not the old value
      host_wdata <= ~d;
   endtask
endmodule // hfa_host_model

// >>> test/hfa_host_fifo_port_tb.sv
// Self-checking bench for the host FIFO port block
`include "hfa_consts.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
   $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module hfa_host_fifo_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [2:0]  sv = 3'h0;
   logic [31:0] sd [3] = '{32'h0, 32'h0, 32'h0};
   wire  [2:0]  rdy;
   logic        txd_out_ready = 1'b0;
   logic        link_up = 1'b1;
   logic        err_evt = 1'b0;
   logic        tx_en = 1'b0;
   logic        took_q = 1'b0;
   logic        seen_q = 1'b0;
   logic [31:0] lfsr = 32'h64b9d541;
   logic [31:0] e_v, m_v, d [3];
   logic [31:0] exp_q [$], msk_q [$], tx_q [$];
   int          num_errors = 0;
   int          tests_run = 0;
   wire         host_cs, host_rd, host_wr, txd_out_valid, soft_rst_q;
   wire  [5:0]  host_addr;
   wire  [31:0] host_wdata, host_rdata_q, txd_out_data, wo_q;
   wire  [7:0]  keep_q;

   hfa_host_model hfa_host_model_inst (
      .ref_clk, .host_cs, .host_rd, .host_wr, .host_addr, .host_wdata);
   hfa_host_fifo_port hfa_host_fifo_port_inst (
      .ref_clk, .arst_n, .host_cs, .host_rd, .host_wr, .host_addr,
      .host_wdata, .host_rdata_q,
      .rxs_in_valid(sv[0]), .rxs_in_ready(rdy[0]), .rxs_in_data(sd[0]),
      .rxd_in_valid(sv[1]), .rxd_in_ready(rdy[1]), .rxd_in_data(sd[1]),
      .txs_in_valid(sv[2]), .txs_in_ready(rdy[2]), .txs_in_data(sd[2]),
      .txd_out_valid, .txd_out_ready, .txd_out_data, .link_up, .err_evt,
      .soft_rst_q, .keep_q, .wo_q);

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic rd(input logic [5:0] a, input logic [31:0] e, m,
                     input int n = 1);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      hfa_host_model_inst.acc(1'b0, a, 32'h0, n);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      hfa_host_model_inst.acc(1'b1, a, v, 1);
   endtask
   // Valid held until taken or n edges pass (refusal case)
   task automatic push(input int s, input logic [31:0] v, input int n);
      @(posedge ref_clk);
      sv[s] <= 1'b1;
      sd[s] <= v;
      repeat (n) begin
         @(posedge ref_clk);
         if (rdy[s]) break;
      end
      sv[s] <= 1'b0;
      sd[s] <= ~v;
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      lfsr <= nxt(lfsr);
      txd_out_ready <= tx_en & lfsr[3];
      took_q <= host_cs & host_rd & ~seen_q;
      seen_q <= host_cs & (seen_q | host_rd);
      if (took_q) begin
         m_v = msk_q.pop_front();
         e_v = exp_q.pop_front();
         `CHK(host_rdata_q & m_v, e_v)
      end
      if (txd_out_valid && txd_out_ready) begin
         e_v = tx_q.pop_front();
         `CHK(txd_out_data, e_v)
      end
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rd(`HFA_CTRL, 32'h0000_0444, 32'h80ff_0777);
      wr(`HFA_CTRL, 32'h0000_0443);
      for (int i = 0; i < 3; i++) begin
         d[i] = lfsr;
         push(1, d[i], 4);
      end
      push(1, lfsr, 2);
      rd(`HFA_STS, 32'h0000_0301, 32'h0000_0701);
      wr(`HFA_STS, 32'h0);
      rd(`HFA_STS, 32'h1, 32'h1);
      wr(`HFA_STS, 32'h00ff_ff01);
      rd(`HFA_STS, 32'h0000_0300, 32'h0000_0701);
      wr(6'h07, lfsr);
      for (int i = 0; i < 3; i++)
         rd(6'(i * 7), d[i], '1, (i == 0) ? 2 : 1);
      rd(6'h0f, 32'h0, '1);
      rd(`HFA_STS, 32'h0, 32'h0000_0700);
      d[0] = lfsr;
      push(0, d[0], 4);
      d[1] = lfsr;
      push(0, d[1], 4);
      wr(`HFA_RXS_POP, lfsr);
      rd(`HFA_RXS_VIEW, d[0], '1);
      rd(`HFA_RXS_VIEW, d[0], '1);
      rd(`HFA_RXS_POP, d[0], '1);
      rd(`HFA_RXS_POP, d[1], '1);
      rd(`HFA_RXS_POP, 32'h0, '1);
      d[2] = lfsr;
      push(2, d[2], 4);
      rd(`HFA_STS, 32'h2, 32'h2);
      rd(`HFA_STS, 32'h0, 32'h2);
      rd(`HFA_TXS_VIEW, d[2], '1);
      rd(`HFA_TXS_POP, d[2], '1);
      rd(`HFA_TXS_VIEW, 32'h0, '1);
      @(posedge ref_clk);
      err_evt <= 1'b1;
      link_up <= 1'b0;
      @(posedge ref_clk);
      err_evt <= 1'b0;
      link_up <= 1'b1;
      rd(`HFA_STS, 32'h8, 32'hc);
      rd(`HFA_STS, 32'h4, 32'hc);
      // Fifth write finds the queue full and must be dropped
      for (int i = 0; i < 5; i++) begin
         d[0] = lfsr;
         if (i < 4)
            tx_q.push_back(d[0]);
         wr(6'(31 - i * 3), d[0]);
      end
      rd(6'h1f, 32'h0, '1);
      tx_en <= 1'b1;
      for (int i = 0; i < 80 && tx_q.size() > 0; i++)
         @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
      `CHK(tx_q.size(), 0)
      d[1] = lfsr;
      wr(`HFA_WO, d[1]);
      // Register updates on the edge the task returns at
      @(negedge ref_clk);
      `CHK(wo_q, d[1])
      rd(`HFA_WO, 32'h0, '1);
      wr(`HFA_CTRL, 32'h00a5_0333);
      rd(`HFA_CTRL, 32'h00a5_0333, 32'h80ff_0777);
      push(0, lfsr, 4);
      wr(`HFA_CTRL, 32'h80a5_0333);
      repeat (4) @(posedge ref_clk);
      rd(`HFA_CTRL, 32'h00a5_0444, 32'h80ff_0777);
      rd(`HFA_RXS_POP, 32'h0, '1);
      `CHK(wo_q, 32'h0)
      `CHK(keep_q, 8'ha5)
      stop_test();
   end

   initial begin
      repeat (4000) @(posedge ref_clk);
      num_errors++;
      stop_test();
   end
endmodule // hfa_host_fifo_port_tb

bind hfa_host_fifo_port hfa_host_fifo_port_properties #(.DW(DW))
   hfa_host_fifo_port_properties_inst (
      .ref_clk, .arst_n, .host_cs, .host_rd, .host_wr, .host_addr,
      .host_wdata, .host_rdata_q, .txd_out_valid, .txd_out_ready,
      .txd_out_data, .soft_rst_q, .keep_q);
